// *** design/cpu_load_store_unit.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "lsu_cfg.svh"

module cpu_load_store_unit
  import lsu_pkg::*;
#(
  parameter int DATA_WIDTH = DATA_W,
  parameter int ADDR_WIDTH = ADDR_W,
  parameter int IO_WIDTH = IO_W,
  parameter int PAGE_WIDTH = PAGE_W
) (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic ce,
  // request from decoder
  input wire logic req_valid,
  input wire lsu_req_t req,
  output logic req_ready_ff,
  // read data from the spaces
  input wire logic [DATA_W-1:0] dmem_rdata,
  input wire logic [DATA_W-1:0] io_rdata,
  input wire logic [DATA_W-1:0] pm_rdata,
  input wire logic pm_ack,
  // strobes to the spaces
  output mem_req_t mem_ff,
  // results to the register file
  output wb_t wb_ff,
  output logic done_ff,
  output logic flags_we_ff
);

  // the struct layout is fixed by the package, so other widths cannot be served
  // ports are sized from the package; these parameters only refuse a mismatch
  if (DATA_WIDTH != DATA_W || ADDR_WIDTH != ADDR_W || IO_WIDTH != IO_W || PAGE_WIDTH != PAGE_W) begin : g_chk
    $error("cpu_load_store_unit: widths must match lsu_pkg");
  end

  // sequencer state and its next values
  logic [3:0] cnt_ff; // cycles left including the current one
  logic [3:0] nxt_cnt;
  lsu_job_t job_ff; // transfer in flight
  lsu_job_t nxt_job;
  mem_req_t nxt_mem;
  wb_t nxt_wb;
  logic nxt_done;
  logic nxt_ready;
  // decode of the request on the port
  lsu_job_t new_job; // job decoded from the request
  logic [3:0] new_cyc; // its cycle count

  // cycle count per operation
  function automatic logic [3:0] cycles_of(input op_t op);
    logic [3:0] c;
    c = `LSU_CYC_PLAIN;
    unique case (op)
      OP_LOAD_PREDEC, OP_STORE_PREDEC: c = `LSU_CYC_PREDEC;
      OP_LOAD_DISP, OP_STORE_DISP: c = `LSU_CYC_DISP;
      OP_STORE_DIRECT: c = `LSU_CYC_DIRECT;
      OP_PMEM_LOAD, OP_PMEM_LOAD_POSTINC,
      OP_XPMEM_LOAD, OP_XPMEM_LOAD_POSTINC: c = `LSU_CYC_PMEM;
      OP_POP: c = `LSU_CYC_POP;
      OP_PMEM_STORE, OP_PMEM_STORE_POSTINC: c = `LSU_CYC_PMEM_STORE;
      OP_LOAD_IND, OP_LOAD_POSTINC, OP_STORE_IND, OP_STORE_POSTINC,
      OP_IO_IN, OP_IO_OUT, OP_PUSH: c = `LSU_CYC_PLAIN;
      // codes outside the enum take one cycle so the unit never hangs
      default: c = `LSU_CYC_PLAIN;
    endcase
    return c;
  endfunction

  // strobes for the access cycle of a job
  function automatic mem_req_t strobes_of(input lsu_job_t j);
    mem_req_t m;
    m = '0;
    // address and data always follow the job, only the strobes select a space
    m.dmem_addr = j.addr;
    m.dmem_wdata = j.wdata;
    m.io_addr = j.addr[IO_W-1:0];
    m.io_wdata = j.wdata;
    m.pm_addr = j.pm_addr;
    m.pm_wdata = j.wword;
    unique case (j.op)
      OP_LOAD_IND, OP_LOAD_POSTINC, OP_LOAD_PREDEC, OP_LOAD_DISP, OP_POP: m.dmem_rd = 1'b1;
      OP_STORE_IND, OP_STORE_POSTINC, OP_STORE_PREDEC, OP_STORE_DISP,
      OP_STORE_DIRECT, OP_PUSH: m.dmem_wr = 1'b1;
      OP_PMEM_LOAD, OP_PMEM_LOAD_POSTINC,
      OP_XPMEM_LOAD, OP_XPMEM_LOAD_POSTINC: m.pm_rd = 1'b1;
      OP_PMEM_STORE, OP_PMEM_STORE_POSTINC: m.pm_wr = 1'b1;
      OP_IO_IN: m.io_rd = 1'b1;
      OP_IO_OUT: m.io_wr = 1'b1;
      // an illegal code raises no strobe at all
      default: m.dmem_rd = 1'b0;
    endcase
    return m;
  endfunction

  // decode a request into addresses and updated pointer values
  always_comb begin
    new_job = '0;
    new_job.op = req.op;
    new_job.ptr_sel = req.ptr_sel;
    new_job.wdata = req.src_data;
    new_job.wword = req.r1r0; // r1 high, r0 low
    new_job.ptr_new = req.ptr_val;
    new_job.sp_new = req.sp;
    new_job.addr = req.ptr_val;
    // forms without an operand target register 0
    new_job.reg_idx = req.use_r0 ? '0 : req.reg_idx;
    // plain program loads keep the page bits out of the address
    new_job.pm_addr = {{PAGE_W{1'b0}}, req.ptr_val};
    new_cyc = cycles_of(req.op);
    // each arm only overrides what differs from a plain indirect access
    unique case (req.op)
      OP_LOAD_PREDEC, OP_STORE_PREDEC: begin
        // address is the already decremented pointer
        new_job.ptr_new = req.ptr_val - `LSU_STEP_BYTE;
        new_job.addr = req.ptr_val - `LSU_STEP_BYTE;
      end
      OP_LOAD_POSTINC, OP_STORE_POSTINC: begin
        // access at the old value, step afterwards
        new_job.ptr_new = req.ptr_val + `LSU_STEP_BYTE;
      end
      OP_LOAD_DISP, OP_STORE_DISP: begin
        // pointer itself is left alone
        new_job.addr = req.ptr_val + req.operand;
      end
      OP_STORE_DIRECT: begin
        // operand carries the full data-space address
        new_job.addr = req.operand;
      end
      OP_IO_IN, OP_IO_OUT: begin
        // io space is narrow, upper operand bits are dropped
        new_job.addr = {{(ADDR_W-IO_W){1'b0}}, req.operand[IO_W-1:0]};
      end
      OP_PMEM_LOAD: begin
        // program memory is always reached through pointer_z
        new_job.ptr_sel = PTR_Z;
      end
      OP_PMEM_LOAD_POSTINC: begin
        new_job.ptr_sel = PTR_Z;
        new_job.ptr_new = req.ptr_val + `LSU_STEP_BYTE;
      end
      OP_XPMEM_LOAD: begin
        new_job.ptr_sel = PTR_Z;
        new_job.pm_addr = {req.page_ext, req.ptr_val};
      end
      OP_XPMEM_LOAD_POSTINC: begin
        new_job.ptr_sel = PTR_Z;
        new_job.pm_addr = {req.page_ext, req.ptr_val};
        new_job.ptr_new = req.ptr_val + `LSU_STEP_BYTE;
      end
      OP_PMEM_STORE: begin
        new_job.ptr_sel = PTR_Z;
        new_job.pm_addr = {req.page_ext, req.ptr_val};
      end
      OP_PMEM_STORE_POSTINC: begin
        new_job.ptr_sel = PTR_Z;
        new_job.pm_addr = {req.page_ext, req.ptr_val};
        // a word write steps the byte pointer by two
        new_job.ptr_new = req.ptr_val + `LSU_STEP_WORD;
      end
      OP_PUSH: begin
        // store at the current top, then move down
        new_job.addr = req.sp;
        new_job.sp_new = req.sp - `LSU_STEP_BYTE;
      end
      OP_POP: begin
        // move up first, then read
        new_job.addr = req.sp + `LSU_STEP_BYTE;
        new_job.sp_new = req.sp + `LSU_STEP_BYTE;
      end
      default: begin
        // plain indirect loads and stores use the pointer as is
        new_job.addr = req.ptr_val;
      end
    endcase
  end

  // sequencer: count cycles, raise strobes in the last one, write back at its end
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_job = job_ff;
    nxt_mem = '0; // strobes are single cycle unless held below
    nxt_wb = '0; // write back is a pulse
    nxt_done = 1'b0;
    // last cycle of a transfer: strobes are up, read data is valid now
    if (cnt_ff == 4'h1) begin
      if ((job_ff.op == OP_PMEM_STORE || job_ff.op == OP_PMEM_STORE_POSTINC) && !pm_ack) begin
        // program store has no fixed length; hold the strobe until acknowledged
        // an ack outside a held program store is never looked at
        nxt_mem = mem_ff;
      end else begin
        // access cycle ends: capture read data and finish
        nxt_cnt = 4'h0;
        nxt_done = 1'b1;
        nxt_wb.reg_idx = job_ff.reg_idx;
        nxt_wb.ptr_sel = job_ff.ptr_sel;
        nxt_wb.ptr_data = job_ff.ptr_new;
        nxt_wb.sp_data = job_ff.sp_new;
        unique case (job_ff.op)
          OP_LOAD_IND, OP_LOAD_DISP: begin
            nxt_wb.reg_we = 1'b1;
            nxt_wb.reg_data = dmem_rdata;
          end
          OP_LOAD_POSTINC, OP_LOAD_PREDEC: begin
            nxt_wb.reg_we = 1'b1;
            nxt_wb.reg_data = dmem_rdata;
            nxt_wb.ptr_we = 1'b1;
          end
          OP_STORE_POSTINC, OP_STORE_PREDEC, OP_PMEM_STORE_POSTINC: begin
            nxt_wb.ptr_we = 1'b1;
          end
          OP_PMEM_LOAD, OP_XPMEM_LOAD: begin
            nxt_wb.reg_we = 1'b1;
            nxt_wb.reg_data = pm_rdata;
          end
          OP_PMEM_LOAD_POSTINC, OP_XPMEM_LOAD_POSTINC: begin
            nxt_wb.reg_we = 1'b1;
            nxt_wb.reg_data = pm_rdata;
            nxt_wb.ptr_we = 1'b1;
          end
          OP_IO_IN: begin
            nxt_wb.reg_we = 1'b1;
            nxt_wb.reg_data = io_rdata;
          end
          OP_POP: begin
            nxt_wb.reg_we = 1'b1;
            nxt_wb.reg_data = dmem_rdata;
            nxt_wb.sp_we = 1'b1;
          end
          OP_PUSH: begin
            nxt_wb.sp_we = 1'b1;
          end
          default: begin
            // plain stores and io output only write memory
            nxt_wb.reg_we = 1'b0;
          end
        endcase
      end
    end else if (cnt_ff != 4'h0) begin
      // address cycles: strobes go out for the final cycle
      nxt_cnt = cnt_ff - 4'h1;
      if (nxt_cnt == 4'h1) begin
        nxt_mem = strobes_of(job_ff);
      end
    end else if (req_valid && req_ready_ff) begin
      // accept a new transfer
      nxt_job = new_job;
      nxt_cnt = new_cyc;
      if (new_cyc == 4'h1) begin
        nxt_mem = strobes_of(new_job);
      end
    end
    // ready rises together with done, so the next request may be taken
    // at the edge that ends the done cycle; ready stays a plain flop output
    nxt_ready = (nxt_cnt == 4'h0) && !(cnt_ff == 4'h0 && req_valid && req_ready_ff);
  end

  // every output of the unit is one of these flops
  // state registers, frozen while ce is low
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      // idle and ready, with no strobe or pulse up
      cnt_ff <= `LSU_RST_CNT;
      job_ff <= '0;
      mem_ff <= '0;
      wb_ff <= '0;
      done_ff <= 1'b0;
      req_ready_ff <= `LSU_RST_READY;
      flags_we_ff <= 1'b0;
    end else if (ce) begin
      cnt_ff <= nxt_cnt;
      job_ff <= nxt_job;
      mem_ff <= nxt_mem;
      wb_ff <= nxt_wb;
      done_ff <= nxt_done;
      req_ready_ff <= nxt_ready;
      // transfers never touch the status flags
      flags_we_ff <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// *** design/lsu_cfg.svh ***
`ifndef LSU_CFG_SVH
`define LSU_CFG_SVH

// cycles from the accepting edge to the done pulse
`define LSU_CYC_PLAIN 4'h1
`define LSU_CYC_PREDEC 4'h2
`define LSU_CYC_DISP 4'h2
`define LSU_CYC_DIRECT 4'h2
`define LSU_CYC_PMEM 4'h3
`define LSU_CYC_POP 4'h2
`define LSU_CYC_PMEM_STORE 4'h1

// pointer steps
`define LSU_STEP_BYTE 16'h0001
`define LSU_STEP_WORD 16'h0002

// reset values
`define LSU_RST_CNT 4'h0
`define LSU_RST_READY 1'b1

`endif

// *** design/lsu_pkg.sv ***
package lsu_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 16;
  localparam int IO_W = 6;
  localparam int PAGE_W = 8;
  localparam int REG_W = 5;
  localparam int PM_W = PAGE_W + ADDR_W;

  // transfer operations
  typedef enum logic [4:0] {
    OP_LOAD_IND, OP_LOAD_POSTINC, OP_LOAD_PREDEC, OP_LOAD_DISP,
    OP_STORE_IND, OP_STORE_POSTINC, OP_STORE_PREDEC, OP_STORE_DISP, OP_STORE_DIRECT,
    OP_PMEM_LOAD, OP_PMEM_LOAD_POSTINC, OP_XPMEM_LOAD, OP_XPMEM_LOAD_POSTINC,
    OP_PMEM_STORE, OP_PMEM_STORE_POSTINC,
    OP_IO_IN, OP_IO_OUT, OP_PUSH, OP_POP
  } op_t;

  typedef enum logic [1:0] {PTR_X, PTR_Y, PTR_Z} ptr_sel_t;

  // request from the decoder and register file
  typedef struct packed {
    op_t op;
    logic [REG_W-1:0] reg_idx;
    logic use_r0;
    ptr_sel_t ptr_sel;
    logic [ADDR_W-1:0] ptr_val;
    logic [ADDR_W-1:0] operand;
    logic [DATA_W-1:0] src_data;
    logic [2*DATA_W-1:0] r1r0;
    logic [ADDR_W-1:0] sp;
    logic [PAGE_W-1:0] page_ext;
  } lsu_req_t;

  // job held while a transfer runs
  typedef struct packed {
    op_t op;
    logic [REG_W-1:0] reg_idx;
    ptr_sel_t ptr_sel;
    logic [ADDR_W-1:0] addr;
    logic [PM_W-1:0] pm_addr;
    logic [DATA_W-1:0] wdata;
    logic [2*DATA_W-1:0] wword;
    logic [ADDR_W-1:0] ptr_new;
    logic [ADDR_W-1:0] sp_new;
  } lsu_job_t;

  // strobes toward data, io and program memory
  typedef struct packed {
    logic dmem_rd;
    logic dmem_wr;
    logic [ADDR_W-1:0] dmem_addr;
    logic [DATA_W-1:0] dmem_wdata;
    logic io_rd;
    logic io_wr;
    logic [IO_W-1:0] io_addr;
    logic [DATA_W-1:0] io_wdata;
    logic pm_rd;
    logic pm_wr;
    logic [PM_W-1:0] pm_addr;
    logic [2*DATA_W-1:0] pm_wdata;
  } mem_req_t;

  // write back toward the register file
  typedef struct packed {
    logic reg_we;
    logic [REG_W-1:0] reg_idx;
    logic [DATA_W-1:0] reg_data;
    logic ptr_we;
    ptr_sel_t ptr_sel;
    logic [ADDR_W-1:0] ptr_data;
    logic sp_we;
    logic [ADDR_W-1:0] sp_data;
  } wb_t;

endpackage

// *** tb/cpu_load_store_unit_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module cpu_load_store_unit_tb_top;
  import lsu_pkg::*;
  // expected result of one transfer
  typedef struct packed {
    wb_t wb;
    logic [23:0] a;
    logic [15:0] d;
    logic [5:0] k; // expected strobe kind
    logic [3:0] s; // expected cycles with a strobe up
    logic [3:0] c; // expected edges from accept to done
  } note_t;
  logic clk_sys = 1'b0;
  logic arst_n, ce, req_valid, slow, ready, done, flags_we, pm_ack;
  lsu_req_t req;
  mem_req_t mem_o;
  wb_t wb_o;
  logic [7:0] dmem_rdata, io_rdata, pm_rdata;
  logic [23:0] cap_a; // last strobed address
  logic [15:0] cap_d; // last strobed write data
  logic [5:0] cap_k = 6'h00; // strobe kinds seen since the last done
  int cap_n = 0; // cycles with a strobe up since the last done
  int lat = 0; // enabled edges since the last accept
  logic [19:0] lfsr = 20'h12255;
  int mismatches = 0, n_checks = 0, cyc = 0;
  note_t notes[$];
  always #50 clk_sys = ~clk_sys;
  cpu_load_store_unit dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .ce(ce), .req_valid(req_valid), .req(req),
    .req_ready_ff(ready), .dmem_rdata(dmem_rdata), .io_rdata(io_rdata), .pm_rdata(pm_rdata), .pm_ack(pm_ack),
    .mem_ff(mem_o), .wb_ff(wb_o), .done_ff(done), .flags_we_ff(flags_we));
  lsu_mem_model mem_u (.clk_sys(clk_sys), .arst_n(arst_n), .mem_ff(mem_o), .slow(slow), .dmem_rdata(dmem_rdata),
    .io_rdata(io_rdata), .pm_rdata(pm_rdata), .pm_ack(pm_ack));
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[18:0], lfsr[19] ^ lfsr[16]};
    return lfsr[15:0];
  endfunction
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // data fields only matter where their enable is expected
  task automatic chk_wb(input wb_t e, input wb_t g);
    n_checks++;
    if ({g.reg_we, g.ptr_we, g.sp_we} !== {e.reg_we, e.ptr_we, e.sp_we}
        || (e.reg_we && {g.reg_idx, g.reg_data} !== {e.reg_idx, e.reg_data})
        || (e.ptr_we && {g.ptr_sel, g.ptr_data} !== {e.ptr_sel, e.ptr_data})
        || (e.sp_we && g.sp_data !== e.sp_data)) begin
      mismatches++;
      $display("Error writeback expected %h seen %h", e, g);
    end
  endtask
  // build one request, note its outcome, hold it until taken
  task automatic xfer(input op_t o, input logic z, input logic [15:0] p);
    note_t n;
    logic [15:0] a;
    while (ready !== 1'b1) @(negedge clk_sys);
    req = '0;
    req.op = o;
    req.use_r0 = z;
    req.ptr_val = p;
    req.ptr_sel = ptr_sel_t'(o % 3); // program ops must still come out on pointer_z
    req.operand = rnd();
    req.r1r0 = rnd();
    req.sp = rnd();
    a = rnd();
    req.src_data = a[7:0];
    req.page_ext = a[15:8];
    a = rnd();
    req.reg_idx = a[4:0];
    case (o)
      OP_LOAD_PREDEC, OP_STORE_PREDEC: a = p - 16'h1;
      OP_LOAD_DISP, OP_STORE_DISP: a = p + req.operand;
      OP_STORE_DIRECT: a = req.operand;
      OP_IO_IN, OP_IO_OUT: a = {10'h0, req.operand[5:0]};
      OP_PUSH: a = req.sp;
      OP_POP: a = req.sp + 16'h1;
      default: a = p;
    endcase
    n = '0;
    n.a = {o inside {OP_XPMEM_LOAD, OP_XPMEM_LOAD_POSTINC, OP_PMEM_STORE, OP_PMEM_STORE_POSTINC} ? req.page_ext : 8'h00, a};
    n.d = o inside {OP_PMEM_STORE, OP_PMEM_STORE_POSTINC} ? req.r1r0 : {8'h00, req.src_data};
    n.wb.reg_we = o inside {[OP_LOAD_IND:OP_LOAD_DISP], [OP_PMEM_LOAD:OP_XPMEM_LOAD_POSTINC], OP_IO_IN, OP_POP};
    n.wb.reg_idx = z ? 5'h00 : req.reg_idx;
    n.wb.reg_data = o == OP_IO_IN ? a[7:0] ^ 8'hC3 : o inside {[OP_PMEM_LOAD:OP_XPMEM_LOAD_POSTINC]} ?
      n.a[7:0] ^ n.a[23:16] : a[7:0] ^ a[15:8] ^ 8'h5A;
    n.wb.ptr_we = o inside {OP_LOAD_POSTINC, OP_LOAD_PREDEC, OP_STORE_POSTINC, OP_STORE_PREDEC,
      OP_PMEM_LOAD_POSTINC, OP_XPMEM_LOAD_POSTINC, OP_PMEM_STORE_POSTINC};
    n.wb.ptr_sel = o inside {[OP_PMEM_LOAD:OP_PMEM_STORE_POSTINC]} ? PTR_Z : req.ptr_sel;
    n.wb.ptr_data = o inside {OP_LOAD_PREDEC, OP_STORE_PREDEC} ? a : o == OP_PMEM_STORE_POSTINC ? p + 16'h2 : p + 16'h1;
    n.wb.sp_we = o inside {OP_PUSH, OP_POP};
    n.wb.sp_data = o == OP_PUSH ? req.sp - 16'h1 : a;
    n.k = o inside {[OP_LOAD_IND:OP_LOAD_DISP], OP_POP} ? 6'h20 :
      o inside {[OP_STORE_IND:OP_STORE_DIRECT], OP_PUSH} ? 6'h10 : o == OP_IO_IN ? 6'h08 :
      o == OP_IO_OUT ? 6'h04 : o inside {[OP_PMEM_LOAD:OP_XPMEM_LOAD_POSTINC]} ? 6'h02 : 6'h01;
    // the slow flash answers on the fourth cycle of a held program store
    n.s = o inside {OP_PMEM_STORE, OP_PMEM_STORE_POSTINC} && slow ? 4'h4 : 4'h1;
    n.c = o inside {OP_LOAD_PREDEC, OP_LOAD_DISP, OP_STORE_PREDEC, OP_STORE_DISP, OP_STORE_DIRECT, OP_POP} ? 4'h2 :
      o inside {[OP_PMEM_LOAD:OP_XPMEM_LOAD_POSTINC]} ? 4'h3 : n.s;
    notes.push_back(n);
    req_valid = 1'b1;
    while (ready === 1'b1) @(negedge clk_sys);
    req_valid = 1'b0;
  endtask
  // strobe capture, then result check on done
  always @(negedge clk_sys) begin
    note_t nt;
    if (mem_o.dmem_rd | mem_o.dmem_wr | mem_o.io_rd | mem_o.io_wr | mem_o.pm_rd | mem_o.pm_wr) begin
      cap_k = cap_k | {mem_o.dmem_rd, mem_o.dmem_wr, mem_o.io_rd, mem_o.io_wr, mem_o.pm_rd, mem_o.pm_wr};
      cap_n++;
      cap_a = mem_o.pm_rd | mem_o.pm_wr ? mem_o.pm_addr : mem_o.io_rd | mem_o.io_wr ? {18'h0, mem_o.io_addr} :
        {8'h00, mem_o.dmem_addr};
      cap_d = mem_o.pm_wr ? mem_o.pm_wdata : mem_o.io_wr ? {8'h00, mem_o.io_wdata} : {8'h00, mem_o.dmem_wdata};
    end
    if (arst_n && done === 1'b1) begin
      nt = notes.pop_front();
      chk_wb(nt.wb, wb_o);
      chk("address", nt.a, cap_a);
      if (!nt.wb.reg_we) chk("write data", {8'h00, nt.d}, {8'h00, cap_d});
      chk("strobe kind", {18'h0, nt.k}, {18'h0, cap_k});
      chk("strobe cycles", {20'h0, nt.s}, 24'(cap_n));
      chk("cycles", {20'h0, nt.c}, 24'(lat));
      chk("flags write", 24'h0, {23'h0, flags_we});
      cap_k = 6'h00;
      cap_n = 0;
    end
  end
  // hang guard, and edges counted from the accepting edge
  always @(posedge clk_sys) begin
    cyc++;
    if (arst_n && ce && req_valid && ready === 1'b1) lat = 0;
    else if (ce) lat++;
    if (cyc == 3000) begin
      mismatches++;
      report_and_stop();
    end
  end
  initial begin
    {arst_n, ce, req_valid, slow} = 4'h4;
    req = '0;
    repeat (5) @(negedge clk_sys);
    arst_n = 1'b1;
    // every operation, random and with the pointer at 0000 or FFFF
    for (int i = 0; i < 19; i++) begin
      xfer(op_t'(i), 1'b0, rnd());
      xfer(op_t'(i), 1'b0, i[0] ? 16'h0000 : 16'hFFFF);
    end
    $display("test all_ops done");
    xfer(OP_PMEM_LOAD, 1'b1, rnd());
    xfer(OP_XPMEM_LOAD_POSTINC, 1'b1, 16'hFFFF);
    slow = 1'b1;
    xfer(OP_PMEM_STORE_POSTINC, 1'b0, rnd());
    while (ready !== 1'b1) @(negedge clk_sys);
    // let the done pulse pass first, a frozen done would be seen twice
    @(negedge clk_sys);
    ce = 1'b0;
    fork
      xfer(OP_POP, 1'b0, rnd());
      begin
        repeat (3) @(negedge clk_sys);
        ce = 1'b1;
      end
    join
    $display("test slow_and_frozen done");
    xfer(OP_POP, 1'b0, rnd());
    arst_n = 1'b0;
    notes.delete();
    @(negedge clk_sys);
    chk("ready in reset", 24'h1, {23'h0, ready});
    chk("done in reset", 24'h0, {23'h0, done});
    arst_n = 1'b1;
    xfer(OP_PUSH, 1'b0, rnd());
    repeat (6) @(negedge clk_sys);
    chk("pending notes", 24'h0, 24'(notes.size()));
    $display("test reset_mid_run done");
    report_and_stop();
  end
endmodule
`default_nettype wire

// *** tb/lsu_mem_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module lsu_mem_model
  import lsu_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // strobes in, slow delays the flash ack
  input wire mem_req_t mem_ff,
  input wire logic slow,
  // answers
  output logic [DATA_W-1:0] dmem_rdata,
  output logic [DATA_W-1:0] io_rdata,
  output logic [DATA_W-1:0] pm_rdata,
  output logic pm_ack
);
  logic [7:0] noise_ff; // changes each cycle so stale data never passes
  logic [1:0] wait_ff; // cycles the program store has waited
  // noise and wait counters
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      noise_ff <= 8'hA5;
      wait_ff <= 2'h0;
    end else begin
      noise_ff <= {noise_ff[6:0], ~noise_ff[7]};
      wait_ff <= mem_ff.pm_wr ? wait_ff + 2'h1 : 2'h0;
    end
  end
  // data valid only while its strobe is up
  assign dmem_rdata = mem_ff.dmem_rd ? mem_ff.dmem_addr[7:0] ^ mem_ff.dmem_addr[15:8] ^ 8'h5A : noise_ff;
  assign io_rdata = mem_ff.io_rd ? {2'h0, mem_ff.io_addr} ^ 8'hC3 : ~noise_ff;
  assign pm_rdata = mem_ff.pm_rd ? mem_ff.pm_addr[7:0] ^ mem_ff.pm_addr[23:16] : noise_ff;
  // flash write ends at once, or after three waits
  assign pm_ack = mem_ff.pm_wr && (wait_ff == (slow ? 2'h3 : 2'h0));
endmodule
`default_nettype wire

// *** tb/lsu_monitor.sv ***
`timescale 1ns/1ns
`default_nettype none
module lsu_monitor
  import lsu_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // request side
  input wire logic ce,
  input wire logic req_valid,
  input wire lsu_req_t req,
  input wire logic req_ready_ff,
  input wire logic pm_ack,
  // results
  input wire mem_req_t mem_ff,
  input wire wb_t wb_ff,
  input wire logic done_ff,
  input wire logic flags_we_ff
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // accepted request, its pointer and stack value
  wire logic acc = ce && req_valid && req_ready_ff;
  wire op_t op = req.op;
  wire logic [15:0] p = req.ptr_val;
  wire logic [15:0] s = req.sp;
  flag_clear_a:
    assert property (!flags_we_ff) else $error("flag write seen");
  predec_ld_a:
    assert property (acc && op == OP_LOAD_PREDEC |-> ##2 mem_ff.dmem_rd && mem_ff.dmem_addr == $past(p, 2) - 16'h1
      ##1 done_ff && wb_ff.ptr_data == $past(p, 3) - 16'h1) else $error("predec load wrong");
  postinc_ld_a:
    assert property (acc && op == OP_LOAD_POSTINC |-> ##1 mem_ff.dmem_rd && mem_ff.dmem_addr == $past(p)
      ##1 done_ff && wb_ff.ptr_data == $past(p, 2) + 16'h1) else $error("postinc load wrong");
  postinc_st_a:
    assert property (acc && op == OP_STORE_POSTINC |-> ##1 mem_ff.dmem_wr && mem_ff.dmem_addr == $past(p)
      ##1 done_ff && wb_ff.ptr_data == $past(p, 2) + 16'h1) else $error("postinc store wrong");
  pmem_ld_a:
    assert property (acc && op inside {OP_PMEM_LOAD, OP_PMEM_LOAD_POSTINC} |-> ##1 !done_ff [*2]
      ##1 mem_ff.pm_rd && mem_ff.pm_addr == {8'h00, $past(p, 3)} ##1 done_ff) else $error("pmem load wrong");
  xpmem_ld_a:
    assert property (acc && op inside {OP_XPMEM_LOAD, OP_XPMEM_LOAD_POSTINC} |-> ##3 mem_ff.pm_rd
      && mem_ff.pm_addr == {$past(req.page_ext, 3), $past(p, 3)} ##1 done_ff) else $error("xpmem load wrong");
  pm_hold_a:
    assert property (mem_ff.pm_wr && !pm_ack |=> mem_ff.pm_wr && $stable(mem_ff.pm_wdata))
      else $error("pmem store dropped");
  push_a:
    assert property (acc && op == OP_PUSH |-> ##1 mem_ff.dmem_wr && mem_ff.dmem_addr == $past(s)
      ##1 done_ff && wb_ff.sp_data == $past(s, 2) - 16'h1) else $error("push wrong");
  pop_a:
    assert property (acc && op == OP_POP |-> ##2 mem_ff.dmem_rd && mem_ff.dmem_addr == $past(s, 2) + 16'h1
      ##1 done_ff && wb_ff.sp_we) else $error("pop wrong");
endmodule
bind cpu_load_store_unit lsu_monitor mon_u (.clk_sys(clk_sys), .arst_n(arst_n), .ce(ce), .req_valid(req_valid),
  .req(req), .req_ready_ff(req_ready_ff), .pm_ack(pm_ack), .mem_ff(mem_ff), .wb_ff(wb_ff), .done_ff(done_ff),
  .flags_we_ff(flags_we_ff));
`default_nettype wire
